// >>> design/tmr_irq_pkg.sv
// Constants, register map and carrier types of the timer interrupt and run control block
package tmr_irq_pkg;

    // Channel organisation
    localparam int unsigned NUM_CH    = 8;
    localparam int unsigned NUM_PAIRS = 4;
    localparam int unsigned CNT_W     = 8;
    localparam int unsigned ADDR_MIN  = 18;

    // Register indices; the byte address is four times the index
    localparam logic [15:0] IDX_EN03   = 16'hff25;
    localparam logic [15:0] IDX_FLG03  = 16'hff29;
    localparam logic [15:0] IDX_EN47   = 16'hff2c;
    localparam logic [15:0] IDX_FLG47  = 16'hff2e;
    localparam logic [15:0] IDX_PRIO   = 16'hff40;
    localparam logic [15:0] IDX_MODE16 = 16'hff41;
    localparam logic [15:0] IDX_RUN    = 16'hff42;

    // Byte addresses on the bus
    localparam logic [17:0] ADDR_EN03   = {IDX_EN03, 2'b00};
    localparam logic [17:0] ADDR_FLG03  = {IDX_FLG03, 2'b00};
    localparam logic [17:0] ADDR_EN47   = {IDX_EN47, 2'b00};
    localparam logic [17:0] ADDR_FLG47  = {IDX_FLG47, 2'b00};
    localparam logic [17:0] ADDR_PRIO   = {IDX_PRIO, 2'b00};
    localparam logic [17:0] ADDR_MODE16 = {IDX_MODE16, 2'b00};
    localparam logic [17:0] ADDR_RUN    = {IDX_RUN, 2'b00};

    // Field positions inside a packed enable or flag byte
    localparam int unsigned UF_BIT = 0;
    localparam int unsigned MT_BIT = 1;

    // Values after reset
    localparam logic [7:0]  RST_EN     = 8'h00;
    localparam logic [7:0]  RST_FLG    = 8'h00;
    localparam logic [7:0]  RST_PRIO   = 8'h00;
    localparam logic [3:0]  RST_MODE16 = 4'h0;
    localparam logic [7:0]  RST_RUN    = 8'h00;
    localparam logic [7:0]  RST_CNT    = 8'hff;
    localparam logic [31:0] RST_RDATA  = 32'h0000_0000;

    // Plain data byte
    typedef logic [7:0] byte_t;

    // Event flags of all channels
    typedef struct packed {
        logic [NUM_CH-1:0] match;
        logic [NUM_CH-1:0] underflow;
    } chan_evt_t;

    // One Avalon-MM request as seen by the slave
    typedef struct packed {
        logic [17:0] address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } avmm_req_t;

endpackage

// >>> design/timer_irq_run_ctrl.sv
// Timer interrupt flags, enables, priority gating and run/stop/reload control
//
// Decided for this implementation: the Avalon-MM interface to the registers.
`timescale 1ns/1ps

// How it works
// - Per-channel underflow interrupt enable, reset zero
// - Per-channel match interrupt enable, reset zero
// - Cascaded pair ignores low channel enables
// - Underflow sets the underflow event flag
// - Compare match sets the match flag
// - Flags set regardless of enables, priority
// - Request needs flag, enable, priority above CPU
// - Flags read state; write one clears
// - Cascade: low flags silent, high follows 16-bit
// - All event flags clear at reset
// - Run change at input clock fall; one more count
// - Sleep freezes counting; resumes after wake
// - Low counter read does not latch high
// - Decrement and underflow on input clock fall
// - Reload settles at next input clock rise
// - Enables packed two per channel, two registers
// - Flags packed two per channel, two registers
// - Two-bit pair priority, zero means none
module timer_irq_run_ctrl #(
    parameter int unsigned ADDR_W = 18
) (
    // Clock and reset
    input  wire logic                                   I_MCLK,
    input  wire logic                                   I_RESET_N,
    // Avalon-MM register slave
    input  wire logic [ADDR_W-1:0]                      I_AVS_ADDRESS,
    input  wire logic                                   I_AVS_READ,
    input  wire logic                                   I_AVS_WRITE,
    input  wire logic [3:0]                             I_AVS_BYTEENABLE,
    input  wire logic [31:0]                            I_AVS_WRITEDATA,
    output logic      [31:0]                            O_AVS_READDATA,
    output logic                                        O_AVS_WAITREQUEST,
    // Timer input clocks (pins) and counter datapath values
    input  wire logic [tmr_irq_pkg::NUM_CH-1:0]         I_TIMER_CLK,
    input  wire logic [tmr_irq_pkg::NUM_CH-1:0][7:0]    I_RELOAD_VALUE,
    input  wire logic [tmr_irq_pkg::NUM_CH-1:0][7:0]    I_COMPARE_VALUE,
    output logic      [tmr_irq_pkg::NUM_CH-1:0][7:0]    O_COUNTER_VALUE,
    // CPU core side
    input  wire logic                                   I_CPU_LEVEL_BIT_HIGH,
    input  wire logic                                   I_CPU_LEVEL_BIT_LOW,
    input  wire logic                                   I_SLEEP_INSTRUCTION,
    output logic      [tmr_irq_pkg::NUM_PAIRS-1:0]      O_IRQ_REQ
);

    // Refuse an address bus too narrow for the map
    if (ADDR_W < tmr_irq_pkg::ADDR_MIN) begin : g_addr_check
        $error("ADDR_W too small for the register map");
    end

    localparam int unsigned NC = tmr_irq_pkg::NUM_CH;
    localparam int unsigned NP = tmr_irq_pkg::NUM_PAIRS;

    // Bus request carrier and handshake state
    tmr_irq_pkg::avmm_req_t req;            // Current request
    logic                   wait_q;         // Registered waitrequest
    logic [31:0]            rdata_q;        // Registered read data
    logic                   rd_take;        // Read captured this edge
    logic                   wr_acc;         // Write takes effect this edge
    tmr_irq_pkg::byte_t     wbyte;          // Low write lane
    tmr_irq_pkg::byte_t     rd_byte;        // Read mux result

    // Software-visible state
    logic [NC-1:0]          en_uf_q;        // underflow_irq_enable
    logic [NC-1:0]          en_mt_q;        // match_irq_enable
    tmr_irq_pkg::chan_evt_t flg_q;          // Event flags
    logic [7:0]             prio_q;         // irq_priority_field per pair
    logic [NP-1:0]          mode16_q;       // Pair cascade select
    logic [NC-1:0]          run_req_q;      // run_control as written

    // Timer-clock synchronisers and edges
    logic [NC-1:0]          tclk_s1_q;      // First stage, read by stage two only
    logic [NC-1:0]          tclk_s2_q;      // Second stage
    logic [NC-1:0]          tclk_prev_q;    // Delayed copy for edge detect
    logic [NC-1:0]          fall_w;         // Input clock falling edge seen
    logic [NC-1:0]          rise_w;         // Input clock rising edge seen

    // Counter state
    logic [NC-1:0][7:0]     cnt_q;          // counter_value
    logic [NC-1:0]          active_q;       // Counting actually running
    logic [NC-1:0]          pend_q;         // Reload waits for rising edge
    logic [NC-1:0]          uf_pulse_q;     // Underflow event, one cycle
    logic [NC-1:0]          mt_pulse_q;     // Match event, one cycle

    // Derived interrupt terms
    logic [NC-1:0]          low16_w;        // Channel is a cascaded low half
    logic [NC-1:0]          clr_uf;         // Flag clear strobes
    logic [NC-1:0]          clr_mt;
    logic [NC-1:0]          qual_w;         // Enabled and set, per channel
    logic [NP-1:0]          pair_pend_w;    // Any qualified flag in pair
    logic [1:0]             cpu_level;      // CPU interrupt level
    logic [NC-1:0]          run_rd;         // Run bit as read back

    // Pack uf/mt bits of four channels into one byte, even/odd bits
    function automatic tmr_irq_pkg::byte_t pack_half(input logic [7:0] uf,
                                                     input logic [7:0] mt,
                                                     input logic       hi);
        tmr_irq_pkg::byte_t r;
        int                 ch;
        r = '0;
        for (int k = 0; k < 4; k++) begin
            ch = hi ? k + 4 : k;
            r[2*k+tmr_irq_pkg::UF_BIT] = uf[ch];
            r[2*k+tmr_irq_pkg::MT_BIT] = mt[ch];
        end
        return r;
    endfunction

    // Address match against a byte address constant
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [17:0] c);
        return a == ADDR_W'(c);
    endfunction

    assign req       = '{address:    I_AVS_ADDRESS[17:0],
                         read:       I_AVS_READ,
                         write:      I_AVS_WRITE,
                         byteenable: I_AVS_BYTEENABLE,
                         writedata:  I_AVS_WRITEDATA};
    assign wbyte     = req.writedata[7:0];
    assign rd_take   = req.read && wait_q;
    // Only the low byte lane carries data; other lanes are ignored
    assign wr_acc    = req.write && !wait_q && req.byteenable[0];
    assign cpu_level = {I_CPU_LEVEL_BIT_HIGH, I_CPU_LEVEL_BIT_LOW};

    // Handshake: one wait state, then the access completes
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wait_q <= 1'b1;
        end else if ((req.read || req.write) && wait_q) begin
            wait_q <= 1'b0;
        end else begin
            wait_q <= 1'b1;
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rd_byte = '0;
        if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_EN03)) begin
            rd_byte = pack_half(en_uf_q, en_mt_q, 1'b0);
        end else if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_EN47)) begin
            rd_byte = pack_half(en_uf_q, en_mt_q, 1'b1);
        end else if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_FLG03)) begin
            rd_byte = pack_half(flg_q.underflow, flg_q.match, 1'b0);
        end else if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_FLG47)) begin
            rd_byte = pack_half(flg_q.underflow, flg_q.match, 1'b1);
        end else if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_PRIO)) begin
            rd_byte = prio_q;
        end else if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_MODE16)) begin
            rd_byte = {4'h0, mode16_q};
        end else if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_RUN)) begin
            rd_byte = run_rd;
        end
    end

    // Read data is captured at the first edge, valid when wait drops
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            rdata_q <= tmr_irq_pkg::RST_RDATA;
        end else if (rd_take) begin
            rdata_q <= {24'h00_0000, rd_byte};
        end
    end

    // Enable registers, packed even/odd per channel
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            en_uf_q <= tmr_irq_pkg::RST_EN;
            en_mt_q <= tmr_irq_pkg::RST_EN;
        end else if (wr_acc) begin
            for (int k = 0; k < 4; k++) begin
                if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_EN03)) begin
                    en_uf_q[k]   <= wbyte[2*k+tmr_irq_pkg::UF_BIT];
                    en_mt_q[k]   <= wbyte[2*k+tmr_irq_pkg::MT_BIT];
                end
                if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_EN47)) begin
                    en_uf_q[k+4] <= wbyte[2*k+tmr_irq_pkg::UF_BIT];
                    en_mt_q[k+4] <= wbyte[2*k+tmr_irq_pkg::MT_BIT];
                end
            end
        end
    end

    // Priority, cascade and run control registers
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            prio_q    <= tmr_irq_pkg::RST_PRIO;
            mode16_q  <= tmr_irq_pkg::RST_MODE16;
            run_req_q <= tmr_irq_pkg::RST_RUN;
        end else if (wr_acc) begin
            if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_PRIO)) begin
                prio_q <= wbyte;
            end
            if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_MODE16)) begin
                mode16_q <= wbyte[3:0];
            end
            if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_RUN)) begin
                // High half of a cascade has no run bit of its own
                for (int c = 0; c < NC; c++) begin
                    run_req_q[c] <= wbyte[c] & ~((c % 2 == 1) && mode16_q[c/2]);
                end
            end
        end
    end

    // Reads 1 from the write until counting has really halted
    assign run_rd = run_req_q | active_q;

    // Flag clear strobes from a write of ones
    always_comb begin
        clr_uf = '0;
        clr_mt = '0;
        if (wr_acc) begin
            for (int k = 0; k < 4; k++) begin
                if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_FLG03)) begin
                    clr_uf[k]   = wbyte[2*k+tmr_irq_pkg::UF_BIT];
                    clr_mt[k]   = wbyte[2*k+tmr_irq_pkg::MT_BIT];
                end
                if (hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_FLG47)) begin
                    clr_uf[k+4] = wbyte[2*k+tmr_irq_pkg::UF_BIT];
                    clr_mt[k+4] = wbyte[2*k+tmr_irq_pkg::MT_BIT];
                end
            end
        end
    end

    // Event flags: a set in the clearing cycle wins over the clear
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            flg_q <= {tmr_irq_pkg::RST_FLG, tmr_irq_pkg::RST_FLG};
        end else begin
            flg_q.underflow <= (flg_q.underflow & ~clr_uf) | uf_pulse_q;
            flg_q.match     <= (flg_q.match & ~clr_mt) | mt_pulse_q;
        end
    end

    // Timer clocks come from pins: two flops, then edge detect
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            tclk_s1_q   <= '0;
            tclk_s2_q   <= '0;
            tclk_prev_q <= '0;
        end else begin
            tclk_s1_q   <= I_TIMER_CLK;
            tclk_s2_q   <= tclk_s1_q;
            tclk_prev_q <= tclk_s2_q;
        end
    end

    assign fall_w = tclk_prev_q & ~tclk_s2_q;
    assign rise_w = tclk_s2_q & ~tclk_prev_q;

    // Counters, run/stop and reload; sleep ignores falling edges
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            cnt_q      <= {NC{tmr_irq_pkg::RST_CNT}};
            active_q   <= '0;
            pend_q     <= '0;
            uf_pulse_q <= '0;
            mt_pulse_q <= '0;
        end else begin
            uf_pulse_q <= '0;
            mt_pulse_q <= '0;
            for (int p = 0; p < NP; p++) begin
                if (mode16_q[p]) begin
                    // Cascade runs on the low channel's clock and run bit
                    active_q[2*p+1] <= 1'b0;
                    pend_q[2*p+1]   <= 1'b0;
                    if (fall_w[2*p] && !I_SLEEP_INSTRUCTION) begin
                        active_q[2*p] <= run_req_q[2*p];
                        if (active_q[2*p]) begin
                            if ({cnt_q[2*p+1], cnt_q[2*p]} == 16'h0000) begin
                                pend_q[2*p]       <= 1'b1;
                                uf_pulse_q[2*p+1] <= 1'b1;
                            end else begin
                                {cnt_q[2*p+1], cnt_q[2*p]} <=
                                    {cnt_q[2*p+1], cnt_q[2*p]} - 16'h0001;
                                if ({cnt_q[2*p+1], cnt_q[2*p]} - 16'h0001 ==
                                    {I_COMPARE_VALUE[2*p+1], I_COMPARE_VALUE[2*p]}) begin
                                    mt_pulse_q[2*p+1] <= 1'b1;
                                end
                            end
                        end
                    end
                    if (rise_w[2*p] && pend_q[2*p]) begin
                        cnt_q[2*p]   <= I_RELOAD_VALUE[2*p];
                        cnt_q[2*p+1] <= I_RELOAD_VALUE[2*p+1];
                        pend_q[2*p]  <= 1'b0;
                    end
                end else begin
                    for (int h = 0; h < 2; h++) begin
                        if (fall_w[2*p+h] && !I_SLEEP_INSTRUCTION) begin
                            active_q[2*p+h] <= run_req_q[2*p+h];
                            if (active_q[2*p+h]) begin
                                if (cnt_q[2*p+h] == 8'h00) begin
                                    pend_q[2*p+h]     <= 1'b1;
                                    uf_pulse_q[2*p+h] <= 1'b1;
                                end else begin
                                    cnt_q[2*p+h] <= cnt_q[2*p+h] - 8'h01;
                                    if (cnt_q[2*p+h] - 8'h01 == I_COMPARE_VALUE[2*p+h]) begin
                                        mt_pulse_q[2*p+h] <= 1'b1;
                                    end
                                end
                            end
                        end
                        if (rise_w[2*p+h] && pend_q[2*p+h]) begin
                            cnt_q[2*p+h]  <= I_RELOAD_VALUE[2*p+h];
                            pend_q[2*p+h] <= 1'b0;
                        end
                    end
                end
            end
        end
    end

    // Low halves of cascades have their enables ignored
    always_comb begin
        for (int c = 0; c < NC; c++) begin
            low16_w[c] = (c % 2 == 0) && mode16_q[c/2];
        end
    end

    // Qualified flags, independent of how the flags got set
    assign qual_w = ((flg_q.underflow & en_uf_q) | (flg_q.match & en_mt_q))
                    & ~low16_w;

    always_comb begin
        for (int p = 0; p < NP; p++) begin
            pair_pend_w[p] = |qual_w[2*p +: 2];
        end
    end

    // Pair request: held while any qualified flag beats the CPU level
    always_ff @(posedge I_MCLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_IRQ_REQ <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                O_IRQ_REQ[p] <= pair_pend_w[p] && (prio_q[2*p +: 2] > cpu_level);
            end
        end
    end

    // Counter halves are separate flops; no read latching of the high half
    assign O_COUNTER_VALUE   = cnt_q;
    assign O_AVS_READDATA    = rdata_q;
    assign O_AVS_WAITREQUEST = wait_q;

    // Checks and coverage
    a_uf_sets_flag: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (|uf_pulse_q) |=> ((flg_q.underflow & $past(uf_pulse_q)) == $past(uf_pulse_q)))
        else $error("underflow event did not set its flag");
    a_mt_sets_flag: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (|mt_pulse_q) |=> ((flg_q.match & $past(mt_pulse_q)) == $past(mt_pulse_q)))
        else $error("match event did not set its flag");
    a_low_half_silent: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        ((uf_pulse_q | mt_pulse_q) & low16_w) == '0)
        else $error("cascaded low half raised an event");
    a_flag_w1c: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (wr_acc && hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_FLG03) && wbyte[1] && !mt_pulse_q[0])
        |=> !flg_q.match[0])
        else $error("write of one did not clear flag");
    a_irq_priority: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        O_IRQ_REQ[0] |-> ($past(prio_q[1:0]) > $past(cpu_level)) && $past(pair_pend_w[0]))
        else $error("request without flag or priority");
    a_irq_holds: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (pair_pend_w[1] && prio_q[3:2] > cpu_level) |=> O_IRQ_REQ[1])
        else $error("qualified pair did not request");
    a_uf_at_zero: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        uf_pulse_q[0] |-> $past(cnt_q[0]) == 8'h00 && $past(active_q[0]))
        else $error("underflow not from zero");
    a_reload_rise: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (pend_q[0] && rise_w[0] && !mode16_q[0]) |=> cnt_q[0] == $past(I_RELOAD_VALUE[0]))
        else $error("reload did not settle on rising edge");
    a_sleep_frozen: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (I_SLEEP_INSTRUCTION && pend_q == '0) |=> cnt_q == $past(cnt_q))
        else $error("counter moved during sleep");
    a_stop_reads_one: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (active_q[0] && !run_req_q[0] && fall_w[0] && !I_SLEEP_INSTRUCTION && !mode16_q[0]
         && cnt_q[0] != 8'h00)
        |-> run_rd[0] ##1 (!active_q[0] && cnt_q[0] == $past(cnt_q[0]) - 8'h01))
        else $error("stop did not count once more and halt");
    a_bus_one_wait: assert property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        (rd_take && hit(I_AVS_ADDRESS, tmr_irq_pkg::ADDR_FLG03))
        |=> !O_AVS_WAITREQUEST && O_AVS_READDATA[7:0] ==
            pack_half($past(flg_q.underflow), $past(flg_q.match), 1'b0))
        else $error("flag read wrong or late");

    c_underflow: cover property (@(posedge I_MCLK) disable iff (!I_RESET_N) |uf_pulse_q);
    c_irq_rise: cover property (@(posedge I_MCLK) disable iff (!I_RESET_N) $rose(O_IRQ_REQ[0]));
    c_cascade_uf: cover property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        mode16_q[0] && uf_pulse_q[1]);
    c_stop_tail: cover property (@(posedge I_MCLK) disable iff (!I_RESET_N)
        active_q[0] && !run_req_q[0] && fall_w[0]);

endmodule

// >>> testbench/cpu_core_model.sv
// CPU core stand-in: interrupt level and sleep state toward the timer
`timescale 1ns/1ps
module cpu_core_model (
    // Bench commands
    input  wire logic       i_clk,
    input  wire logic [1:0] i_level,
    input  wire logic       i_sleep,
    // Core status
    output logic            o_lvl_hi = 1'b0,
    output logic            o_lvl_lo = 1'b0,
    output logic            o_sleep  = 1'b0
);
    // Changes land after an edge, as the servicing software would do
    always @(posedge i_clk) begin
        {o_lvl_hi, o_lvl_lo} <= i_level;
        o_sleep <= i_sleep;
    end
endmodule

// >>> testbench/timer_irq_run_ctrl_test.sv
// Register-level bench of the timer interrupt and run control block
`timescale 1ns/1ps
module timer_irq_run_ctrl_test;
    logic clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, sl = 1'b0, lh, ll, sp;
    logic [17:0] adr = 18'h0;
    logic [31:0] wd = 32'h0, rdat;
    logic [7:0] tclk = 8'hff, q;
    logic [1:0] lvl = 2'h0;
    logic wq;
    logic [3:0] irq;
    logic [7:0][7:0] cnt;
    int failures = 0, check_count = 0;
    localparam logic [17:0] RA [4] = '{tmr_irq_pkg::ADDR_EN03, tmr_irq_pkg::ADDR_FLG03,
        tmr_irq_pkg::ADDR_EN47, tmr_irq_pkg::ADDR_FLG47};
    cpu_core_model cpu (.i_clk(clk), .i_level(lvl), .i_sleep(sl), .o_lvl_hi(lh),
        .o_lvl_lo(ll), .o_sleep(sp));
    timer_irq_run_ctrl DUT (.I_MCLK(clk), .I_RESET_N(rst_n), .I_AVS_ADDRESS(adr),
        .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_BYTEENABLE(4'hf), .I_AVS_WRITEDATA(wd),
        .O_AVS_READDATA(rdat), .O_AVS_WAITREQUEST(wq), .I_TIMER_CLK(tclk),
        .I_RELOAD_VALUE({8{8'h02}}),
        .I_COMPARE_VALUE({8{8'hfd}}), .O_COUNTER_VALUE(cnt),
        .I_CPU_LEVEL_BIT_HIGH(lh), .I_CPU_LEVEL_BIT_LOW(ll), .I_SLEEP_INSTRUCTION(sp),
        .O_IRQ_REQ(irq));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // Compare and count
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            failures++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    // One access; request held until waitrequest is seen low
    task automatic bus(input logic [17:0] a, input logic w, input logic [7:0] d);
        adr <= a; wr <= w; rd <= !w; wd <= {24'h0, d};
        @(posedge clk);
        while (wq !== 1'b0) begin
            @(posedge clk);
        end
        q = rdat[7:0];
        wr <= 1'b0; rd <= 1'b0;
        @(posedge clk);
    endtask
    // Full timer input clock periods, slow enough for the synchronisers
    task automatic tick(input int n);
        repeat (n) begin
            tclk <= 8'h00; repeat (8) @(posedge clk);
            tclk <= 8'hff; repeat (8) @(posedge clk);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d failures=%0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // Hang guard, well beyond the roughly thirteen thousand cycles needed
    initial begin
        repeat (30000) @(posedge clk);
        failures++;
        finish_test;
    end
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (RA[i]) begin bus(RA[i], 0, 0); chk(q, 8'h00); end
        bus(18'h0, 0, 0); chk(q, 8'h00);
        bus(RA[2], 1, 8'ha5); bus(RA[2], 0, 0); chk(q, 8'ha5);
        $display("test 1 done");
        bus(tmr_irq_pkg::ADDR_PRIO, 1, 8'h03); bus(RA[0], 1, 8'h02);
        bus(tmr_irq_pkg::ADDR_RUN, 1, 8'h01); tick(3);
        bus(RA[1], 0, 0); chk(q, 8'h02);
        chk({7'h0, irq[0]}, 8'h01);
        bus(RA[1], 1, 8'h02); repeat (3) @(posedge clk);
        chk({7'h0, irq[0]}, 8'h00);
        bus(RA[1], 0, 0); chk(q, 8'h00);
        tick(254); bus(RA[1], 0, 0); chk(q, 8'h01);
        chk({7'h0, irq[0]}, 8'h00); chk(cnt[0], 8'h02);
        $display("test 2 done");
        bus(RA[0], 1, 8'h01); lvl <= 2'h3; repeat (4) @(posedge clk);
        chk({7'h0, irq[0]}, 8'h00);
        lvl <= 2'h2; repeat (4) @(posedge clk); chk({7'h0, irq[0]}, 8'h01);
        bus(tmr_irq_pkg::ADDR_RUN, 1, 8'h00); bus(tmr_irq_pkg::ADDR_RUN, 0, 0);
        chk(q, 8'h01); tick(1);
        bus(tmr_irq_pkg::ADDR_RUN, 0, 0); chk(q, 8'h00); chk(cnt[0], 8'h01);
        $display("test 3 done");
        sl <= 1'b1; bus(tmr_irq_pkg::ADDR_RUN, 1, 8'h01); tick(3);
        chk(cnt[0], 8'h01); sl <= 1'b0; tick(2); chk(cnt[0], 8'h00);
        $display("test 4 done");
        bus(RA[0], 1, 8'h31); bus(tmr_irq_pkg::ADDR_RUN, 1, 8'h05); tick(3);
        bus(tmr_irq_pkg::ADDR_MODE16, 1, 8'h02); bus(tmr_irq_pkg::ADDR_PRIO, 1, 8'h0f);
        tick(512); bus(RA[1], 0, 0); chk(q, 8'ha1);
        chk({7'h0, irq[1]}, 8'h00);
        bus(RA[0], 1, 8'hb1); repeat (3) @(posedge clk);
        chk({7'h0, irq[1]}, 8'h01);
        chk(cnt[3], 8'hfd); chk(cnt[2], 8'hfd);
        $display("test 5 done");
        finish_test;
    end
endmodule
